// ---- twa_arbiter.sv ----
// bus ownership state machine and external master memory control decode
// How it works
// RULE1 - four states set ownership, drive, bus-driven
// RULE2 - reset input or watchdog forces reset state
// RULE3 - leave reset to implicit if granted, else external
// RULE4 - external state: no bus drive, strobes allowed
// RULE5 - implicit: three-stated until request or lock
// RULE6 - explicit when granted and cycle or lock
// RULE7 - explicit held while grant stays asserted
// RULE8 - grant gone, no lock: finish cycle, release
// RULE9 - end of cycle: any termination, bursts included
// RULE10 - request output registered while grant, driven negated
// RULE11 - arbiter grants only after previous master releases
// RULE12 - own transfer may start cycle after grant
// RULE13 - watch external transfers, drive selects and ack
// RULE14 - external masters issue aligned transfers only
// RULE15 - capture address, direction, size at start edge
// RULE16 - upper address zero when pins repurposed
// RULE17 - ignore type, modifier and mask attribute bits
// RULE18 - system gates start when decode unwanted
// RULE19 - chip select hit asserts select, strobes, ack
// RULE20 - never drive address for select/default accesses
// RULE21 - dram hit: row, column, write, ack, address
// RULE22 - default memory acks after programmed wait states
// RULE23 - one decode clock before wait counter starts
// RULE24 - negate ack, then three-state next edge
module twa_arbiter (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reset_input_n, // external reset pin
  input wire logic watchdog_reset, // software watchdog reset, same clock
  input wire logic bus_grant_in_n, // grant pin from arbiter
  input wire logic bus_lock, // lock bit from system_config_reg
  input wire logic core_bus_req, // core needs bus for operand transfer
  input wire logic cycle_active, // own bus cycle in progress
  input wire logic cycle_end, // own cycle terminated, normal or error
  input wire logic transfer_start_n, // start pin, external master
  input wire logic [twa_pkg::TWA_ADDR_W-1:0] ext_addr, // address pins
  input wire logic ext_read, // direction pin, high for read
  input wire logic [twa_pkg::TWA_SIZE_W-1:0] transfer_size, // size pins
  input wire logic [1:0] transfer_type_code, // not examined
  input wire logic access_type_modifier, // not examined
  input wire logic upper_addr_pins_are_addr, // upper pins used as address
  input wire logic [twa_pkg::TWA_NUM_CS-1:0] cs_hit, // per-select address match
  input wire logic [twa_pkg::TWA_NUM_CS-1:0] cs_rd_en, // per-select read enable
  input wire logic [twa_pkg::TWA_NUM_CS-1:0] cs_wr_en, // per-select write enable
  input wire logic [twa_pkg::TWA_NUM_CS-1:0] cs_auto_ack, // chip_select_control_reg auto-ack
  input wire logic [twa_pkg::TWA_NUM_CS*twa_pkg::TWA_WS_W-1:0] cs_wait_states, // per-select wait states
  input wire logic [twa_pkg::TWA_NUM_RAS-1:0] dram_hit, // per-bank match
  input wire logic [twa_pkg::TWA_NUM_RAS-1:0] dram_rd_en, // per-bank read enable
  input wire logic [twa_pkg::TWA_NUM_RAS-1:0] dram_wr_en, // per-bank write enable
  input wire logic dram_addr_drive_enable, // bit of dram_controller_control_reg
  input wire logic [twa_pkg::TWA_WS_W-1:0] dram_wait_states, // dram access wait states
  input wire logic ext_master_auto_ack, // bit of default_memory_control_reg
  input wire logic [twa_pkg::TWA_WS_W-1:0] wait_state_count, // default memory wait states
  output twa_pkg::twa_own_t own_state, // current ownership state
  output logic bus_request_out_n, // request pin
  output logic bus_driven_out_n, // bus-driven pin
  output logic bus_drive_en, // enable for address, data, start, direction, size
  output logic [twa_pkg::TWA_NUM_CS-1:0] chip_select_n,
  output logic [twa_pkg::TWA_NUM_WE-1:0] write_enable_n,
  output logic [twa_pkg::TWA_NUM_RAS-1:0] row_strobe_n,
  output logic [twa_pkg::TWA_NUM_CAS-1:0] col_strobe_n,
  output logic dram_write_n,
  output logic dram_addr_oe, // drive dram address during external access
  output logic transfer_ack_n_o, // ack pin output value
  output logic transfer_ack_n_oe, // ack pin output enable
  output logic [twa_pkg::TWA_ADDR_W-1:0] em_addr // captured external address
);
  import twa_pkg::*;

  // synchronised pins: reset, grant, start
  logic [2:0] pin_raw, pin_sync; // raw pins and their synchronised copies
  logic rst_pin_n, grant_n, start_n; // synchronised reset, grant, start
  assign pin_raw = {reset_input_n, bus_grant_in_n, transfer_start_n};
  assign rst_pin_n = pin_sync[2];
  assign grant_n = pin_sync[1];
  assign start_n = pin_sync[0];
  // all three pins idle high, so flops reset to ones
  twa_sync #(.W(3)) u_pin_sync (
    .clk(clk),
    .rstn(rstn),
    .d(pin_raw),
    .q(pin_sync)
  );

  // ownership state machine
  twa_own_t next_own_state;
  logic next_bus_request_out_n, next_bus_driven_out_n, next_bus_drive_en;
  logic any_reset, granted; // either reset source; synchronised grant asserted
  assign any_reset = !rst_pin_n || watchdog_reset;
  assign granted = !grant_n;

  // next ownership state
  always_comb begin
    next_own_state = own_state;
    // RULE2 any reset wins
    if (any_reset) begin
      next_own_state = TWA_RESET;
    end else begin
      case (own_state)
        // RULE3 leave on grant level
        TWA_RESET: next_own_state = granted ? TWA_IMPLICIT : TWA_EM_OWN;
        // RULE5 idle owner waits for request or lock
        TWA_IMPLICIT: begin
          if (!granted) begin
            next_own_state = TWA_EM_OWN;
          end else if (bus_lock || core_bus_req) begin
            // RULE12 transfer begins the cycle after grant
            next_own_state = TWA_EXPLICIT;
          end
        end
        TWA_EXPLICIT: begin
          // RULE7 grant held keeps explicit
          if (granted || bus_lock) begin
            next_own_state = TWA_EXPLICIT;
          // RULE8 RULE9 release once idle or terminated
          end else if (!cycle_active || cycle_end) begin
            next_own_state = TWA_EM_OWN;
          end
        end
        TWA_EM_OWN: begin
          if (granted) begin
            // RULE6 cycle or lock means explicit
            next_own_state = (bus_lock || core_bus_req) ? TWA_EXPLICIT : TWA_IMPLICIT;
          end
        end
        default: next_own_state = TWA_RESET;
      endcase
    end
    // RULE1 drive and bus-driven follow the state
    next_bus_driven_out_n = (next_own_state != TWA_EXPLICIT);
    // RULE4 only explicit drives the shared bus
    next_bus_drive_en = (next_own_state == TWA_EXPLICIT);
    // RULE10 request tracks core only while both negated
    next_bus_request_out_n = bus_request_out_n;
    if (any_reset) begin
      next_bus_request_out_n = 1'b1;
    end else if (grant_n && bus_driven_out_n) begin
      next_bus_request_out_n = !core_bus_req;
    end
  end

  // ownership registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      own_state <= TWA_RESET;
      bus_driven_out_n <= 1'b1;
      bus_drive_en <= 1'b0;
      bus_request_out_n <= 1'b1;
    end else begin
      own_state <= next_own_state;
      bus_driven_out_n <= next_bus_driven_out_n;
      bus_drive_en <= next_bus_drive_en;
      bus_request_out_n <= next_bus_request_out_n;
    end
  end

  // external master transfer sequence
  twa_em_t em_state, next_em_state;
  logic [TWA_ADDR_W-1:0] next_em_addr;
  logic em_read, next_em_read; // captured direction, high for read
  logic [TWA_SIZE_W-1:0] em_size, next_em_size; // captured size
  logic [TWA_WS_W-1:0] ws_cnt, next_ws_cnt, cs_ws; // wait counter and selected load
  logic [TWA_NUM_CS-1:0] next_chip_select_n, cs_sel;
  logic [TWA_NUM_WE-1:0] next_write_enable_n, lanes;
  logic [TWA_NUM_RAS-1:0] next_row_strobe_n, dram_sel;
  logic [TWA_NUM_CAS-1:0] next_col_strobe_n;
  logic next_dram_write_n, next_dram_addr_oe;
  logic next_ack_n_o, next_ack_n_oe;
  logic ack_armed, next_ack_armed; // ack will be given for this transfer
  logic cs_ack, ext_start;

  // RULE13 decode only while another master owns the bus
  assign ext_start = !start_n && (own_state == TWA_EM_OWN);

  // per-select qualification; RULE17 attribute and mask bits unused
  genvar gi;
  for (gi = 0; gi < TWA_NUM_CS; gi++) begin : g_cs
    assign cs_sel[gi] = cs_hit[gi] && (em_read ? cs_rd_en[gi] : cs_wr_en[gi]);
  end
  // per-bank qualification by direction
  for (gi = 0; gi < TWA_NUM_RAS; gi++) begin : g_dram
    assign dram_sel[gi] = dram_hit[gi] && (em_read ? dram_rd_en[gi] : dram_wr_en[gi]);
  end

  // pick lowest hit select's wait states and ack enable
  always_comb begin
    cs_ws = TWA_WS_ZERO;
    cs_ack = 1'b0;
    for (int i = TWA_NUM_CS - 1; i >= 0; i--) begin
      if (cs_sel[i]) begin
        cs_ws = cs_wait_states[i*TWA_WS_W +: TWA_WS_W];
        cs_ack = cs_auto_ack[i];
      end
    end
  end

  // byte lanes from size and low address; RULE14 aligned assumed
  always_comb begin
    case (em_size)
      TWA_SIZE_BYTE: lanes = 4'(4'h1 << em_addr[1:0]);
      TWA_SIZE_WORD: lanes = em_addr[1] ? 4'hC : 4'h3;
      default: lanes = 4'hF;
    endcase
  end

  // next values of the transfer sequence
  always_comb begin
    next_em_state = em_state;
    next_em_addr = em_addr;
    next_em_read = em_read;
    next_em_size = em_size;
    next_ws_cnt = ws_cnt;
    next_chip_select_n = chip_select_n;
    next_write_enable_n = write_enable_n;
    next_row_strobe_n = row_strobe_n;
    next_col_strobe_n = col_strobe_n;
    next_dram_write_n = dram_write_n;
    next_dram_addr_oe = dram_addr_oe;
    next_ack_n_o = transfer_ack_n_o;
    next_ack_n_oe = transfer_ack_n_oe;
    next_ack_armed = ack_armed;
    case (em_state)
      TWA_EM_IDLE: begin
        if (ext_start) begin
          // RULE15 capture address, direction, size
          next_em_addr = ext_addr;
          // RULE16 upper bits zero when pins repurposed
          if (!upper_addr_pins_are_addr) begin
            next_em_addr[TWA_ADDR_W-1:TWA_UPPER_LSB] = TWA_UPPER_ZERO;
          end
          next_em_read = ext_read;
          next_em_size = transfer_size;
          // RULE23 one clock spent decoding
          next_em_state = TWA_EM_DECODE;
        end
      end
      TWA_EM_DECODE: begin
        next_em_state = TWA_EM_WAIT;
        // RULE19 select hit asserts select and strobes
        if (|cs_sel) begin
          next_chip_select_n = ~cs_sel;
          next_write_enable_n = em_read ? 4'hF : ~lanes;
          next_ws_cnt = cs_ws;
          next_ack_armed = cs_ack;
        // RULE21 dram hit asserts row, column, write
        end else if (|dram_sel) begin
          next_row_strobe_n = ~dram_sel;
          next_col_strobe_n = ~lanes;
          next_dram_write_n = em_read;
          next_dram_addr_oe = dram_addr_drive_enable;
          next_ws_cnt = dram_wait_states;
          next_ack_armed = 1'b1;
        // RULE22 default memory uses its own ack bit
        end else begin
          next_ws_cnt = wait_state_count;
          next_ack_armed = ext_master_auto_ack;
        end
        // RULE20 address stays with the external master
        if (next_ack_armed) begin
          next_ack_n_oe = 1'b1;
          next_ack_n_o = (next_ws_cnt != TWA_WS_ZERO);
          next_em_state = (next_ws_cnt == TWA_WS_ZERO) ? TWA_EM_ACK : TWA_EM_WAIT;
        end
      end
      TWA_EM_WAIT: begin
        // wait counter runs; without ack we hold until start again or reset
        if (!ack_armed) begin
          next_em_state = ext_start ? TWA_EM_RELEASE : TWA_EM_WAIT;
        end else if (ws_cnt == TWA_WS_ONE) begin
          next_ws_cnt = TWA_WS_ZERO;
          next_ack_n_o = 1'b0;
          next_em_state = TWA_EM_ACK;
        end else begin
          next_ws_cnt = 4'(ws_cnt - TWA_WS_ONE);
        end
      end
      TWA_EM_ACK: begin
        // RULE24 negate ack, release strobes
        next_ack_n_o = 1'b1;
        next_em_state = TWA_EM_RELEASE;
      end
      TWA_EM_RELEASE: begin
        // RULE24 three-state ack next edge
        next_ack_n_oe = 1'b0;
        next_ack_armed = 1'b0;
        next_em_state = TWA_EM_IDLE;
      end
      default: next_em_state = TWA_EM_IDLE;
    endcase
    // strobes drop as the ack is negated
    if (em_state == TWA_EM_ACK || em_state == TWA_EM_RELEASE) begin
      next_chip_select_n = '1;
      next_write_enable_n = '1;
      next_row_strobe_n = '1;
      next_col_strobe_n = '1;
      next_dram_write_n = 1'b1;
      next_dram_addr_oe = 1'b0;
    end
  end

  // transfer sequence registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      em_state <= TWA_EM_IDLE;
      em_addr <= '0;
      em_read <= 1'b1;
      em_size <= TWA_SIZE_LONG;
      ws_cnt <= TWA_WS_ZERO;
      chip_select_n <= '1;
      write_enable_n <= '1;
      row_strobe_n <= '1;
      col_strobe_n <= '1;
      dram_write_n <= 1'b1;
      dram_addr_oe <= 1'b0;
      transfer_ack_n_o <= 1'b1;
      transfer_ack_n_oe <= 1'b0;
      ack_armed <= 1'b0;
    end else begin
      em_state <= next_em_state;
      em_addr <= next_em_addr;
      em_read <= next_em_read;
      em_size <= next_em_size;
      ws_cnt <= next_ws_cnt;
      chip_select_n <= next_chip_select_n;
      write_enable_n <= next_write_enable_n;
      row_strobe_n <= next_row_strobe_n;
      col_strobe_n <= next_col_strobe_n;
      dram_write_n <= next_dram_write_n;
      dram_addr_oe <= next_dram_addr_oe;
      transfer_ack_n_o <= next_ack_n_o;
      transfer_ack_n_oe <= next_ack_n_oe;
      ack_armed <= next_ack_armed;
    end
  end
endmodule

// ---- twa_pkg.sv ----
// constants and types for the three-wire arbiter and external master decode
package twa_pkg;
  // ownership states, codes written out
  typedef enum logic [1:0] {
    TWA_RESET = 2'b00,
    TWA_IMPLICIT = 2'b01,
    TWA_EXPLICIT = 2'b10,
    TWA_EM_OWN = 2'b11
  } twa_own_t;
  // external master transfer sequence
  typedef enum logic [2:0] {
    TWA_EM_IDLE = 3'b000,
    TWA_EM_DECODE = 3'b001,
    TWA_EM_WAIT = 3'b010,
    TWA_EM_ACK = 3'b011,
    TWA_EM_RELEASE = 3'b100
  } twa_em_t;
  localparam int TWA_ADDR_W = 28;
  localparam int TWA_UPPER_LSB = 24;
  localparam int TWA_NUM_CS = 8;
  localparam int TWA_NUM_WE = 4;
  localparam int TWA_NUM_RAS = 2;
  localparam int TWA_NUM_CAS = 4;
  localparam int TWA_WS_W = 4;
  localparam int TWA_SIZE_W = 2;
  localparam logic [3:0] TWA_UPPER_ZERO = 4'h0;
  localparam logic [TWA_WS_W-1:0] TWA_WS_ZERO = 4'h0;
  localparam logic [TWA_WS_W-1:0] TWA_WS_ONE = 4'h1;
  // size encodings used for byte lanes
  localparam logic [1:0] TWA_SIZE_LONG = 2'h0;
  localparam logic [1:0] TWA_SIZE_BYTE = 2'h1;
  localparam logic [1:0] TWA_SIZE_WORD = 2'h2;
  localparam logic [1:0] TWA_SIZE_LINE = 2'h3;
endpackage

// ---- twa_sync.sv ----
// two-flop synchroniser, one per bit
module twa_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;
  // first stage feeds only the second stage
  always_comb begin
    next_meta = d;
    next_q = meta;
  end
  // both stages reset to ones: every synchronised pin idles high
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '1;
      q <= '1;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule

// ---- twa_arbiter_asserts.sv ----
// concurrent checks on the ownership machine and external ack pins
module twa_arbiter_chk
  import twa_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic reset_input_n,
  input wire logic watchdog_reset,
  input wire logic bus_grant_in_n,
  input wire logic core_bus_req,
  input wire logic upper_addr_pins_are_addr,
  input wire twa_pkg::twa_own_t own_state,
  input wire logic bus_request_out_n,
  input wire logic bus_driven_out_n,
  input wire logic bus_drive_en,
  input wire logic transfer_ack_n_o,
  input wire logic transfer_ack_n_oe,
  input wire logic [twa_pkg::TWA_ADDR_W-1:0] em_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  import twa_pkg::*;
  // one clock domain, async reset disables all
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  state_drive_a: assert property (
    (own_state == TWA_EXPLICIT) == (!bus_driven_out_n && bus_drive_en))
    else $error("bus driven pins disagree with state");
  em_float_a: assert property (
    own_state == TWA_EM_OWN |-> !bus_drive_en && bus_driven_out_n)
    else $error("bus driven while another master owns it");
  wd_reset_a: assert property (
    watchdog_reset |-> ##[1:2] own_state == TWA_RESET)
    else $error("watchdog did not force reset state");
  leave_reset_a: assert property (
    $past(own_state) == TWA_RESET && own_state != TWA_RESET |-> own_state != TWA_EXPLICIT)
    else $error("reset left straight to explicit");
  // grant held steadily keeps explicit ownership
  hold_grant_a: assert property (
    (!bus_grant_in_n && reset_input_n && !watchdog_reset)[*3] ##0 own_state == TWA_EXPLICIT
    ##1 !watchdog_reset |-> own_state == TWA_EXPLICIT)
    else $error("explicit ownership lost under grant");
  ack_shape_a: assert property (
    transfer_ack_n_oe && !transfer_ack_n_o |=> transfer_ack_n_oe && transfer_ack_n_o ##1 !transfer_ack_n_oe)
    else $error("ack not negated then released");
  req_track_a: assert property (
    $changed(bus_request_out_n) && !$past(watchdog_reset)
    |-> $past(bus_driven_out_n) && bus_request_out_n == !$past(core_bus_req))
    else $error("request pin moved wrongly");
  upper_zero_a: assert property (
    $changed(em_addr) && !upper_addr_pins_are_addr |-> em_addr[27:24] == 4'h0)
    else $error("upper captured address not zero");
  ack_em_a: assert property (
    transfer_ack_n_oe |-> own_state == TWA_EM_OWN)
    else $error("ack driven outside external ownership");
endmodule
bind twa_arbiter twa_arbiter_chk twa_arbiter_chk_inst (.clk, .rstn, .reset_input_n, .watchdog_reset,
  .bus_grant_in_n, .core_bus_req, .upper_addr_pins_are_addr, .own_state, .bus_request_out_n,
  .bus_driven_out_n, .bus_drive_en, .transfer_ack_n_o, .transfer_ack_n_oe, .em_addr);

// ---- twa_partner.sv ----
// model of the external arbiter and a second bus master
module twa_partner
  import twa_pkg::*;
(
  input wire logic clk,
  input wire logic transfer_ack_n_o,
  input wire logic transfer_ack_n_oe,
  output logic bus_grant_in_n,
  output logic transfer_start_n,
  output logic [twa_pkg::TWA_ADDR_W-1:0] ext_addr,
  output logic ext_read,
  output logic [twa_pkg::TWA_SIZE_W-1:0] transfer_size
);
  timeunit 1ns;
  timeprecision 1ps;
  import twa_pkg::*;
  logic ack_wire_n; // ack pin level, pulled up when undriven
  assign ack_wire_n = transfer_ack_n_oe ? transfer_ack_n_o : 1'b1;
  initial begin
    bus_grant_in_n = 1'b1;
    transfer_start_n = 1'b1;
    ext_addr = 28'h5A5A5A5;
    ext_read = 1'b0;
    transfer_size = TWA_SIZE_LINE;
  end
  task automatic grant(input logic g);
    @(negedge clk);
    bus_grant_in_n = !g;
  endtask
  // only aligned long transfers; start is a one-cycle pulse
  task automatic xfer(input logic [TWA_ADDR_W-1:0] a, input logic rd, output int lat);
    @(negedge clk);
    ext_addr = a;
    ext_read = rd;
    transfer_size = TWA_SIZE_LONG;
    // start raised only when decode is wanted
    transfer_start_n = 1'b0;
    @(negedge clk);
    transfer_start_n = 1'b1;
    // bounded wait for ack, address held meanwhile
    for (lat = 1; lat < 20 && ack_wire_n !== 1'b0; lat++) begin
      @(negedge clk);
    end
    if (ack_wire_n !== 1'b0) begin
      lat = -1;
    end
  endtask
  // release after the ack edge; lines show a changed pattern, not stale data
  task automatic drop();
    @(negedge clk);
    ext_addr = ~ext_addr;
    ext_read = ~ext_read;
    transfer_size = ~transfer_size;
  endtask
endmodule

// ---- twa_arbiter_tb.sv ----
// self-checking bench for the ownership machine and external decode
module twa_arbiter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import twa_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, reset_input_n = 1'b0, watchdog_reset = 1'b0, bus_lock = 1'b0;
  logic core_bus_req = 1'b0, cycle_active = 1'b0, cycle_end = 1'b0, access_type_modifier = 1'b0;
  logic upper_addr_pins_are_addr = 1'b1, dram_addr_drive_enable = 1'b0, ext_master_auto_ack = 1'b1;
  logic [1:0] transfer_type_code = 2'h0;
  logic [TWA_NUM_CS-1:0] cs_hit = 8'h00, cs_rd_en = 8'hFF, cs_wr_en = 8'hFF, cs_auto_ack = 8'h00;
  logic [TWA_NUM_CS*TWA_WS_W-1:0] cs_wait_states = 32'h0;
  logic [TWA_NUM_RAS-1:0] dram_hit = 2'h0, dram_rd_en = 2'h3, dram_wr_en = 2'h3;
  logic [TWA_WS_W-1:0] dram_wait_states = 4'h0, wait_state_count = 4'h0;
  logic bus_grant_in_n, transfer_start_n, ext_read, bus_request_out_n, bus_driven_out_n, bus_drive_en;
  logic dram_write_n, dram_addr_oe, transfer_ack_n_o, transfer_ack_n_oe;
  logic [TWA_ADDR_W-1:0] ext_addr, em_addr;
  logic [TWA_SIZE_W-1:0] transfer_size;
  logic [TWA_NUM_CS-1:0] chip_select_n;
  logic [TWA_NUM_WE-1:0] write_enable_n;
  logic [TWA_NUM_RAS-1:0] row_strobe_n;
  logic [TWA_NUM_CAS-1:0] col_strobe_n;
  twa_own_t own_state;
  int n_errors = 0;
  int checked = 0;
  int lat0, lat2; // ack latencies, compared not absolute
  always #4 clk = ~clk;
  twa_arbiter twa_arbiter_inst (.clk, .rstn, .reset_input_n, .watchdog_reset, .bus_grant_in_n, .bus_lock,
    .core_bus_req, .cycle_active, .cycle_end, .transfer_start_n, .ext_addr, .ext_read, .transfer_size,
    .transfer_type_code, .access_type_modifier, .upper_addr_pins_are_addr, .cs_hit, .cs_rd_en, .cs_wr_en,
    .cs_auto_ack, .cs_wait_states, .dram_hit, .dram_rd_en, .dram_wr_en, .dram_addr_drive_enable,
    .dram_wait_states, .ext_master_auto_ack, .wait_state_count, .own_state, .bus_request_out_n,
    .bus_driven_out_n, .bus_drive_en, .chip_select_n, .write_enable_n, .row_strobe_n, .col_strobe_n,
    .dram_write_n, .dram_addr_oe, .transfer_ack_n_o, .transfer_ack_n_oe, .em_addr);
  twa_partner twa_partner_inst (.clk, .transfer_ack_n_o, .transfer_ack_n_oe, .bus_grant_in_n,
    .transfer_start_n, .ext_addr, .ext_read, .transfer_size);
  task automatic print_verdict();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // bounded wait for a state; grant and start pass two sync flops
  task automatic wait_own(input twa_own_t tgt);
    int i;
    for (i = 0; i < 20 && own_state !== tgt; i++) begin
      @(negedge clk);
    end
    check(own_state, tgt);
    if (i == 20) print_verdict();
  endtask
  task automatic hold_own(input twa_own_t tgt, input int n);
    repeat (n) begin
      @(negedge clk);
      check(own_state, tgt);
    end
  endtask
  task automatic xfer_ok(input logic [TWA_ADDR_W-1:0] a, input logic rd, output int lat);
    twa_partner_inst.xfer(a, rd, lat);
    if (lat < 0) begin
      n_errors++;
      print_verdict();
    end
  endtask
  // after the ack cycle: negated, strobes off, then released
  task automatic ack_tail();
    twa_partner_inst.drop();
    check({transfer_ack_n_o, transfer_ack_n_oe, chip_select_n, row_strobe_n}, 12'hFFF);
    @(negedge clk);
    check(transfer_ack_n_oe, 1'b0);
    @(negedge clk);
  endtask
  task automatic t_req();
    core_bus_req = 1'b1;
    @(negedge clk);
    check(bus_request_out_n, 1'b0);
    core_bus_req = 1'b0;
    @(negedge clk);
    check(bus_request_out_n, 1'b1);
    $display("test request done");
  endtask
  task automatic t_xfer();
    xfer_ok(28'hABCDEF0, 1'b1, lat0);
    check(em_addr, 28'hABCDEF0);
    ack_tail();
    // two wait states, upper pins repurposed, attribute pins wiggled
    wait_state_count = 4'h2;
    upper_addr_pins_are_addr = 1'b0;
    transfer_type_code = 2'h3;
    access_type_modifier = 1'b1;
    xfer_ok(28'h9876540, 1'b0, lat2);
    check(em_addr, 28'h0876540);
    check(lat2 - lat0, 2);
    ack_tail();
    // chip select 3 acks by itself, default ack off
    ext_master_auto_ack = 1'b0;
    cs_rd_en = 8'h08;
    cs_hit = 8'h08;
    cs_auto_ack = 8'h08;
    cs_wait_states = 32'h00001000;
    xfer_ok(28'h0001000, 1'b0, lat2);
    check(lat2 - lat0, 1);
    check({chip_select_n, write_enable_n, dram_addr_oe}, {8'hF7, 4'h0, 1'b0});
    ack_tail();
    cs_hit = 8'h00;
    dram_hit = 2'h1;
    dram_addr_drive_enable = 1'b1;
    dram_wait_states = 4'h3;
    xfer_ok(28'h0002000, 1'b0, lat2);
    check(lat2 - lat0, 3);
    check({row_strobe_n, col_strobe_n, dram_write_n, dram_addr_oe}, {2'h2, 4'h0, 1'b0, 1'b1});
    ack_tail();
    dram_hit = 2'h0;
    $display("test transfers done");
  endtask
  task automatic t_own();
    twa_partner_inst.grant(1'b1);
    wait_own(TWA_IMPLICIT);
    hold_own(TWA_IMPLICIT, 3);
    check(bus_drive_en, 1'b0);
    core_bus_req = 1'b1;
    wait_own(TWA_EXPLICIT);
    core_bus_req = 1'b0;
    cycle_active = 1'b1;
    hold_own(TWA_EXPLICIT, 4);
    twa_partner_inst.grant(1'b0);
    hold_own(TWA_EXPLICIT, 5);
    cycle_end = 1'b1;
    @(negedge clk);
    cycle_end = 1'b0;
    cycle_active = 1'b0;
    wait_own(TWA_EM_OWN);
    $display("test ownership done");
  endtask
  task automatic t_lock();
    bus_lock = 1'b1;
    twa_partner_inst.grant(1'b1);
    wait_own(TWA_EXPLICIT);
    twa_partner_inst.grant(1'b0);
    hold_own(TWA_EXPLICIT, 5);
    bus_lock = 1'b0;
    wait_own(TWA_EM_OWN);
    $display("test lock done");
  endtask
  task automatic t_wd();
    core_bus_req = 1'b1;
    twa_partner_inst.grant(1'b1);
    wait_own(TWA_EXPLICIT);
    watchdog_reset = 1'b1;
    core_bus_req = 1'b0;
    repeat (2) @(negedge clk);
    check({own_state, bus_driven_out_n}, {TWA_RESET, 1'b1});
    watchdog_reset = 1'b0;
    wait_own(TWA_IMPLICIT);
    twa_partner_inst.grant(1'b0);
    wait_own(TWA_EM_OWN);
    $display("test watchdog done");
  endtask
  initial begin
    repeat (2) @(negedge clk);
    check(own_state, TWA_RESET);
    rstn = 1'b1;
    reset_input_n = 1'b1;
    wait_own(TWA_EM_OWN);
    check({bus_driven_out_n, bus_drive_en}, 2'b10);
    t_req();
    t_xfer();
    t_own();
    t_lock();
    t_wd();
    print_verdict();
  end
endmodule
